/* sim/tb_tmrc_top.sv */
// Self-checking bench for the dual timer/event counter.
// Assumes the Avalon slave answers with one low waitrequest cycle.
`timescale 1ns/100ps

module tb_tmrc_top;
  import tmrc_pkg::*;
  logic clk_sys, nrst, ce, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic pin0, pin1, xtal, ovf0, ovf1, go, busy;
  logic [7:0] num;
  int bad_count, tests_run, seed, cyc, n, w;

  tmrc_top dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .counter0_event_pin(pin0),
    .counter1_event_pin(pin1), .low_freq_crystal_clock(xtal),
    .counter0_ovf(ovf0), .counter1_ovf(ovf1));

  tmrc_pin_model far (.clk_sys(clk_sys), .go(go), .num(num),
    .idle_lvl(1'b0), .pin(pin1), .busy(busy));

  // ****************************************************************
  // Clock, timeout, report
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Whole run is about 6k cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // Bus tasks and comparisons
  // ****************************************************************
  function automatic logic [31:0] ctl(input logic [1:0] m,
      input logic s, input logic r, input logic e, input logic [2:0] p);
    return {24'h000000, m, s, r, e, p};
  endfunction

  // Request held until waitrequest is seen low; then one idle edge
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk_sys);
    // No local limit: only the run ceiling may end a hung access
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rng(input logic [31:0] got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi || ^got === 1'bx) begin
      bad_count++;
      $display("ERROR %0t got %h want %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    tests_run++;
    if (rd !== exp) begin
      bad_count++;
      $display("ERROR %0t addr %h got %h exp %h", $time, a, rd, exp);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {ce, avs_read, avs_write, pin0, xtal, go} = 6'b100000;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    num = 8'h00;
    bad_count = 0;
    tests_run = 0;
    seed = 56943;
    nrst = 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    // Reset values, unmapped place, ignored byte lane
    rdc(OFF_CTL0, 32'h08);
    rdc(OFF_CTL1, 32'h08);
    rdc(OFF_CNT0, 32'h00);
    rdc(5'h18, 32'h00);
    avs_byteenable <= 4'h0;
    bus(1'b1, OFF_CTL0, 32'h55);
    avs_byteenable <= 4'hF;
    rdc(OFF_CTL0, 32'h08);
    // Stopped preload write lands in the count at once
    w = $random(seed) & 32'hFF;
    bus(1'b1, OFF_CNT0, w);
    rdc(OFF_CNT0, w);
    // Overflow reload and one-cycle request
    bus(1'b1, OFF_CNT0, 32'hFC);
    bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b0, 1'b1, 1'b0, 3'h0));
    n = 0;
    while (ovf0 !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    rng(ovf0, 1, 1);
    @(posedge clk_sys);
    rng(ovf0, 0, 0);
    bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b0, 1'b0, 1'b0, 3'h0));
    // A wrap during the stop write may still pulse; none may follow
    repeat (2) @(posedge clk_sys);
    rng(ovf0, 0, 0);
    // Running preload write leaves the live count alone
    bus(1'b1, OFF_CNT0, 32'h80);
    bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b0, 1'b1, 1'b0, 3'h7));
    bus(1'b1, OFF_CNT0, 32'h10);
    bus(1'b0, OFF_CNT0, 32'h0);
    rng(rd, 8'h80, 8'h81);
    // Prescale codes: 20 ticks of 2^k cycles each
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b0, 1'b0, 1'b0, k));
      bus(1'b1, OFF_CNT0, 32'h00);
      bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b0, 1'b1, 1'b0, k));
      repeat (20 << k) @(posedge clk_sys);
      bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b0, 1'b0, 1'b0, k));
      bus(1'b0, OFF_CNT0, 32'h0);
      rng(rd, 18, 23);
      rdc(OFF_CNT0, rd);
    end
    // Crystal source counts falling edges; PWM forces system clock
    bus(1'b1, OFF_CNT0, 32'h00);
    bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b1, 1'b1, 1'b0, 3'h0));
    n = ($random(seed) & 15) + 1;
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      xtal <= 1'b1;
      repeat (4) @(posedge clk_sys);
      xtal <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    rdc(OFF_CNT0, n);
    bus(1'b1, OFF_MISC, 32'h01);
    repeat (40) @(posedge clk_sys);
    bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b1, 1'b0, 1'b0, 3'h0));
    bus(1'b0, OFF_CNT0, 32'h0);
    rng(rd, n + 40, n + 46);
    bus(1'b1, OFF_MISC, 32'h00);
    // Event counting on both edges, random pulse counts
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, OFF_CTL1, ctl(2'h1, 1'b0, 1'b0, e, 3'h0));
      bus(1'b1, OFF_CNT1, 32'h00);
      bus(1'b1, OFF_CTL1, ctl(2'h1, 1'b0, 1'b1, e, 3'h0));
      num <= ($random(seed) & 31) + 1;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      @(posedge clk_sys);
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
        @(posedge clk_sys);
        n++;
      end
      rng(busy, 0, 0);
      repeat (4) @(posedge clk_sys);
      bus(1'b1, OFF_CTL1, ctl(2'h1, 1'b0, 1'b0, e, 3'h0));
      rdc(OFF_CNT1, num);
    end
    // Pin level stays readable; idle mode never counts
    pin0 <= 1'b1;
    bus(1'b1, OFF_CTL1, ctl(2'h0, 1'b0, 1'b1, 1'b0, 3'h0));
    repeat (40) @(posedge clk_sys);
    rdc(OFF_PINS, 32'h01);
    rdc(OFF_CNT1, num);
    // Capture counts quarter-clock ticks only while the pin is low
    bus(1'b1, OFF_CTL1, ctl(2'h3, 1'b0, 1'b0, 1'b0, 3'h0));
    bus(1'b1, OFF_CNT1, 32'h00);
    bus(1'b1, OFF_CTL1, ctl(2'h3, 1'b0, 1'b1, 1'b0, 3'h0));
    repeat (200) @(posedge clk_sys);
    bus(1'b1, OFF_CTL1, ctl(2'h3, 1'b0, 1'b0, 1'b0, 3'h0));
    bus(1'b0, OFF_CNT1, 32'h0);
    rng(rd, 50, 53);
    // Counter 1 wraps to its own preload and pulses its request
    bus(1'b1, OFF_CNT1, 32'hFE);
    bus(1'b1, OFF_CTL1, ctl(2'h2, 1'b0, 1'b1, 1'b0, 3'h0));
    n = 0;
    while (ovf1 !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    rng(ovf1, 1, 1);
    bus(1'b1, OFF_CTL1, ctl(2'h2, 1'b0, 1'b0, 1'b0, 3'h0));
    bus(1'b0, OFF_CNT1, 32'h0);
    rng(rd, 8'hFE, 8'hFF);
    // Clock enable low freezes a running counter for 20 cycles
    bus(1'b1, OFF_CNT0, 32'h00);
    bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b0, 1'b1, 1'b0, 3'h0));
    ce <= 1'b0;
    repeat (20) @(posedge clk_sys);
    ce <= 1'b1;
    bus(1'b1, OFF_CTL0, ctl(2'h2, 1'b0, 1'b0, 1'b0, 3'h0));
    bus(1'b0, OFF_CNT0, 32'h0);
    rng(rd, 3, 3);
    complete_run();
  end
endmodule

/* sim/tmrc_pin_model.sv */
// Outside event source driving one counter event pin.
// Assumes the bench pulses go for one cycle and waits on busy.
`timescale 1ns/100ps

module tmrc_pin_model (
  // Clock and command
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [7:0] num,
  input wire logic idle_lvl,
  // Pin and status
  output logic pin,
  output logic busy
);
  logic [8:0] left_ff;
  logic [1:0] ph_ff;

  initial begin
    pin = 1'b0;
    busy = 1'b0;
    left_ff = 9'h000;
    ph_ff = 2'h0;
  end

  // Num full pulses, 4 cycles per level so every edge survives sync
  always @(posedge clk_sys) begin
    if (go && !busy) begin
      left_ff <= {num, 1'b0};
      busy <= 1'b1;
      ph_ff <= 2'h0;
      pin <= idle_lvl;
    end else if (busy) begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == 2'h3) begin
        if (left_ff == 9'h000) begin
          busy <= 1'b0;
        end else begin
          pin <= ~pin;
          left_ff <= left_ff - 9'h001;
        end
      end
    end
  end
endmodule

/* verilog/tmrc_counter.sv */
// One 8-bit up-counter with preload, mode decode and overflow pulse.
// Assumes pin_lvl is already synchronised and int_tick is one cycle.
`timescale 1ns/100ps

module tmrc_counter
  import tmrc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Count sources
  input wire logic int_tick,
  input wire logic pin_lvl,
  // Configuration and preload write
  input wire tmrc_ctrl_t ctrl,
  input wire logic pl_we,
  input wire logic [CNT_W-1:0] pl_data,
  // Results
  output logic [CNT_W-1:0] count,
  output logic ovf
);

  // ****************************************************************
  // Count qualification
  // ****************************************************************
  logic pin_d_ff;
  logic [CNT_W-1:0] preload_ff;
  logic [CNT_W-1:0] count_ff;
  logic ovf_ff;
  logic inc;
  logic [CNT_W-1:0] reload;

  // Delayed pin level for edge detection
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_d_ff <= 1'b0;
    end else if (ce) begin
      pin_d_ff <= pin_lvl;
    end
  end

  // Mode decode selects the advancing source
  always_comb begin
    inc = 1'b0;
    case (ctrl.mode)
      MODE_EVENT: inc = ctrl.edge_sel ? (pin_d_ff && !pin_lvl)
                                      : (!pin_d_ff && pin_lvl);
      MODE_TIMER: inc = int_tick;
      MODE_PWC: inc = int_tick && (pin_lvl == ctrl.edge_sel);
      default: inc = 1'b0;
    endcase
    inc = inc && ctrl.run;
  end

  // A write landing on an overflow cycle is the value reloaded
  assign reload = pl_we ? pl_data : preload_ff;

  // ****************************************************************
  // Preload and count registers
  // ****************************************************************
  // Preload has no reset: its power-up content is undefined
  always_ff @(posedge clk_sys) begin
    if (ce && pl_we) begin
      preload_ff <= pl_data;
    end
  end

  // Count advances by one and reloads past full
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_ff <= CNT_ZERO;
    end else if (ce) begin
      if (pl_we && !ctrl.run) begin
        count_ff <= pl_data;
      end else if (inc && count_ff == CNT_FULL) begin
        count_ff <= reload;
      end else if (inc) begin
        count_ff <= count_ff + CNT_STEP;
      end
    end
  end

  // One-cycle overflow request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ovf_ff <= 1'b0;
    end else if (ce) begin
      ovf_ff <= inc && count_ff == CNT_FULL && !(pl_we && !ctrl.run);
    end
  end

  assign count = count_ff;
  assign ovf = ovf_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  cnt_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && inc && count_ff != CNT_FULL && !pl_we
    |=> count_ff == $past(count_ff) + CNT_STEP)
    else $error("count did not advance by one");

  ovf_reload_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && inc && count_ff == CNT_FULL && ctrl.run
    |=> ovf_ff && count_ff == $past(reload))
    else $error("overflow did not reload and flag");

  halt_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !ctrl.run && !pl_we |=> $stable(count_ff))
    else $error("stopped counter moved");

  load_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && pl_we && !ctrl.run |=> count_ff == $past(pl_data))
    else $error("preload write did not reach count");

  load_on_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && pl_we && ctrl.run && count_ff != CNT_FULL && !inc
    |=> $stable(count_ff))
    else $error("running count took preload early");

  no_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl.mode == MODE_NONE |-> !inc)
    else $error("counter advanced with no mode");

endmodule

/* verilog/tmrc_pkg.sv */
// Shared constants and types for the dual 8-bit timer/event counter.
// Assumes one system clock domain and an Avalon-MM register slave.
package tmrc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int CNT_W = 8;
  localparam int NUM_CNT = 2;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int PSC_W = 7;
  localparam int NUM_SYNC = 3;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_CNT0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CTL0 = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CNT1 = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_CTL1 = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_MISC = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_PINS = 5'h14;

  // ****************************************************************
  // Field positions, reset values, fixed counts
  // ****************************************************************
  localparam int MISC_PWM_BIT = 0;
  localparam int PINS_EV0_BIT = 0;
  localparam int PINS_EV1_BIT = 1;
  localparam int PINS_LXT_BIT = 2;
  localparam int SYNC_LXT = 2;
  localparam logic [7:0] CTL_RESET = 8'h08;
  localparam logic [7:0] CTL1_MASK = 8'hF8;
  localparam logic [CNT_W-1:0] CNT_FULL = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;
  localparam logic [PSC_W-1:0] PSC_STEP = 7'h01;
  localparam logic [1:0] INST_DIV_LAST = 2'h3;
  localparam logic [1:0] INST_DIV_STEP = 2'h1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_NONE  = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PWC   = 2'h3
  } tmrc_mode_t;

  // Same bit layout as the control byte seen by software
  typedef struct packed {
    tmrc_mode_t mode;
    logic src;
    logic run;
    logic edge_sel;
    logic [2:0] psc;
  } tmrc_ctrl_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK  = 2'h1
  } tmrc_bus_t;

  typedef enum logic [2:0] {
    SEL_CNT0 = 3'h0,
    SEL_CTL0 = 3'h1,
    SEL_CNT1 = 3'h2,
    SEL_CTL1 = 3'h3,
    SEL_MISC = 3'h4,
    SEL_PINS = 3'h5,
    SEL_NONE = 3'h7
  } tmrc_sel_t;

endpackage

/* verilog/tmrc_top.sv */
// Dual 8-bit timer/event counter with Avalon-MM register slave.
// Assumes event pins and crystal level are synchronous-safe via the
// local synchronisers and that ce stays high across a bus access.
`timescale 1ns/100ps

module tmrc_top
  import tmrc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Outside inputs
  input wire logic counter0_event_pin,
  input wire logic counter1_event_pin,
  input wire logic low_freq_crystal_clock,
  // Overflow requests to the interrupt controller
  output logic counter0_ovf,
  output logic counter1_ovf
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tmrc_bus_t bus_ff;
  logic wait_ff;
  logic [DATA_W-1:0] rdata_ff;
  tmrc_ctrl_t ctrl_ff [NUM_CNT];
  logic pwm_en_ff;
  logic [NUM_SYNC-1:0] sync1_ff;
  logic [NUM_SYNC-1:0] sync2_ff;
  logic [NUM_SYNC-1:0] raw_in;
  logic lxt_d_ff;
  logic [1:0] inst_div_ff;
  logic [PSC_W-1:0] psc_cnt_ff;
  logic lxt_tick;
  logic inst_tick;
  logic src0_tick;
  logic [NUM_CNT-1:0] int_tick;
  logic [NUM_CNT-1:0] pl_we;
  logic [NUM_CNT-1:0] ovf;
  logic [CNT_W-1:0] count [NUM_CNT];
  logic wr_go;
  tmrc_sel_t sel;
  logic [7:0] rd_byte;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Shared by the read path and the write path
  function automatic tmrc_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
    tmrc_sel_t s;
    s = SEL_NONE;
    case (addr)
      OFF_CNT0: s = SEL_CNT0;
      OFF_CTL0: s = SEL_CTL0;
      OFF_CNT1: s = SEL_CNT1;
      OFF_CTL1: s = SEL_CTL1;
      OFF_MISC: s = SEL_MISC;
      OFF_PINS: s = SEL_PINS;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  // Low mask of n ones; the prescaler fires when those bits are all set
  function automatic logic [PSC_W-1:0] psc_mask(input logic [2:0] code);
    logic [7:0] one_hot;
    logic [7:0] m;
    one_hot = 8'h01 << code;
    m = one_hot - 8'h01;
    return m[PSC_W-1:0];
  endfunction

  assign sel = reg_sel(avs_address);

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Each access: seen in IDLE, completed at the edge leaving ACK
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_ff <= BUS_IDLE;
      wait_ff <= 1'b1;
    end else if (ce) begin
      case (bus_ff)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_ff <= BUS_ACK;
            wait_ff <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_ff <= BUS_IDLE;
          wait_ff <= 1'b1;
        end
        default: begin
          bus_ff <= BUS_IDLE;
          wait_ff <= 1'b1;
        end
      endcase
    end
  end

  // Writes take effect only at the edge where waitrequest is low
  assign wr_go = ce && bus_ff == BUS_ACK && avs_write && avs_byteenable[0];

  // Read mux; unmapped addresses and upper lanes read as zero
  always_comb begin
    rd_byte = 8'h00;
    case (sel)
      SEL_CNT0: rd_byte = count[0];
      SEL_CTL0: rd_byte = ctrl_ff[0];
      SEL_CNT1: rd_byte = count[1];
      SEL_CTL1: rd_byte = ctrl_ff[1] & CTL1_MASK;
      SEL_MISC: rd_byte[MISC_PWM_BIT] = pwm_en_ff;
      SEL_PINS: begin
        rd_byte[PINS_EV0_BIT] = sync2_ff[0];
        rd_byte[PINS_EV1_BIT] = sync2_ff[1];
        rd_byte[PINS_LXT_BIT] = sync2_ff[SYNC_LXT];
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data captured as waitrequest drops, held through ACK
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else if (ce && bus_ff == BUS_IDLE && avs_read) begin
      rdata_ff <= {{(DATA_W-8){1'b0}}, rd_byte};
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Counter 1 has no prescaler, so its low three bits stay zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff[0] <= CTL_RESET;
      ctrl_ff[1] <= CTL_RESET & CTL1_MASK;
    end else if (wr_go) begin
      if (sel == SEL_CTL0) begin
        ctrl_ff[0] <= avs_writedata[7:0];
      end
      if (sel == SEL_CTL1) begin
        ctrl_ff[1] <= avs_writedata[7:0] & CTL1_MASK;
      end
    end
  end

  // PWM enable lives here only for its effect on the counter 0 clock source
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwm_en_ff <= 1'b0;
    end else if (wr_go && sel == SEL_MISC) begin
      pwm_en_ff <= avs_writedata[MISC_PWM_BIT];
    end
  end

  // Preload writes go straight to the counters
  assign pl_we[0] = wr_go && sel == SEL_CNT0;
  assign pl_we[1] = wr_go && sel == SEL_CNT1;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  assign raw_in = {low_freq_crystal_clock, counter1_event_pin,
                   counter0_event_pin};

  // Stage one feeds stage two only; everything else reads stage two
  generate
    for (genvar i = 0; i < NUM_SYNC; i++) begin : g_sync
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          sync1_ff[i] <= 1'b0;
          sync2_ff[i] <= 1'b0;
        end else if (ce) begin
          sync1_ff[i] <= raw_in[i];
          sync2_ff[i] <= sync1_ff[i];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Clock sources and prescaler
  // ****************************************************************
  // Crystal counted on its high-to-low transition
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lxt_d_ff <= 1'b0;
    end else if (ce) begin
      lxt_d_ff <= sync2_ff[SYNC_LXT];
    end
  end

  assign lxt_tick = lxt_d_ff && !sync2_ff[SYNC_LXT];

  // Instruction clock is one enable in four system cycles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      inst_div_ff <= 2'h0;
    end else if (ce) begin
      inst_div_ff <= inst_div_ff + INST_DIV_STEP;
    end
  end

  assign inst_tick = inst_div_ff == INST_DIV_LAST;

  // PWM forces the system clock; otherwise the source bit decides
  assign src0_tick = (pwm_en_ff || !ctrl_ff[0].src) ? 1'b1
                                                      : lxt_tick;

  // Free-running prescaler; a tick every 2^code source ticks
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      psc_cnt_ff <= '0;
    end else if (ce && src0_tick) begin
      psc_cnt_ff <= psc_cnt_ff + PSC_STEP;
    end
  end

  assign int_tick[0] = ce && src0_tick
    && ((psc_cnt_ff & psc_mask(ctrl_ff[0].psc)) == psc_mask(ctrl_ff[0].psc));
  assign int_tick[1] = ce && (ctrl_ff[1].src ? lxt_tick : inst_tick);

  // ****************************************************************
  // Counters
  // ****************************************************************
  // Pin direction setup belongs to software, so pins are always watched
  generate
    for (genvar n = 0; n < NUM_CNT; n++) begin : g_cnt
      tmrc_counter u_cnt (
        .clk_sys (clk_sys),
        .nrst (nrst),
        .ce (ce),
        .int_tick (int_tick[n]),
        .pin_lvl (sync2_ff[n]),
        .ctrl (ctrl_ff[n]),
        .pl_we (pl_we[n]),
        .pl_data (avs_writedata[CNT_W-1:0]),
        .count (count[n]),
        .ovf (ovf[n])
      );
    end
  endgenerate

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign counter0_ovf = ovf[0];
  assign counter1_ovf = ovf[1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  wait_drop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && bus_ff == BUS_IDLE && (avs_read || avs_write)
    |=> !avs_waitrequest)
    else $error("waitrequest did not drop");

  wait_once_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  read_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && bus_ff == BUS_IDLE && avs_read && sel == SEL_CNT0
    |=> avs_readdata[CNT_W-1:0] == $past(count[0]))
    else $error("counter read did not return live count");

  pwm_src_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && pwm_en_ff && ctrl_ff[0].psc == 3'h0 |-> int_tick[0])
    else $error("PWM did not force system clock");

  quarter_clk_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && inst_tick && !ctrl_ff[1].src ##1 ce
    |-> !int_tick[1])
    else $error("quarter clock ticked twice in a row");

  pin_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && bus_ff == BUS_IDLE && avs_read && sel == SEL_PINS
    |=> avs_readdata[PINS_EV0_BIT] == $past(sync2_ff[0]))
    else $error("pin level not readable");

  sync_delay_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce ##1 ce |-> sync2_ff[0] == $past(counter0_event_pin, 2))
    else $error("event pin not delayed two stages");

  ctl1_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_ff[1].psc == 3'h0)
    else $error("counter 1 holds prescale bits");

endmodule
